// file: hdl/stopt_params.svh
`ifndef STOPT_PARAMS_SVH
`define STOPT_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define STOPT_OFF_CTRL        12'h000
`define STOPT_OFF_STATUS      12'h004
`define STOPT_OFF_CMD         12'h008
`define STOPT_OFF_RESULT      12'h00C
`define STOPT_OFF_SAVED       12'h010
`define STOPT_OFF_RETRY       12'h014

// ----------------------------------------------------------------------
// Control register fields and reset value.
// ----------------------------------------------------------------------
`define STOPT_CTRL_UA_SET     0
`define STOPT_CTRL_UA_CLR     1
`define STOPT_CTRL_SDTR_SENT  2
`define STOPT_CTRL_PERR_CLR   3
`define STOPT_CTRL_RESET      32'h0000_0000

// ----------------------------------------------------------------------
// Status register fields.
// ----------------------------------------------------------------------
`define STOPT_ST_LAMP_MODE    0
`define STOPT_ST_SYNC_REQ     1
`define STOPT_ST_PARITY_EN    2
`define STOPT_ST_RETRY_INF    3
`define STOPT_ST_UA_RPT       4
`define STOPT_ST_DIAG         5
`define STOPT_ST_LEGACY       6
`define STOPT_ST_PER_DEF      7
`define STOPT_ST_UA_PEND      8
`define STOPT_ST_PERR         9
`define STOPT_ST_SDTR_DUE     10
`define STOPT_ST_RETRY_OUT    11

// ----------------------------------------------------------------------
// Command opcodes, page codes and figures.
// ----------------------------------------------------------------------
`define STOPT_OP_INQUIRY      8'h12
`define STOPT_OP_REQ_SENSE    8'h03
`define STOPT_OP_PRIO_RSV     8'hE4
`define STOPT_OP_MODE_SENSE   8'h1A
`define STOPT_OP_VERIFY       8'h2F
`define STOPT_PAGE_ALL        6'h3F
`define STOPT_PAGE_RW         6'h01
`define STOPT_PAGE_DISC       6'h02
`define STOPT_PAGE_GEOM       6'h04
`define STOPT_PAGE_VERIFY     6'h07
`define STOPT_PAGE_CACHE      6'h08
`define STOPT_VER_NEW         3'h2
`define STOPT_VER_OLD         3'h1
`define STOPT_FMT_NEW         4'h2
`define STOPT_FMT_OLD         4'h1
`define STOPT_CAPS_NEW        8'h18
`define STOPT_LEGACY_SENSE    8'h04
`define STOPT_RETRY_LIMIT     8'h0A
`define STOPT_MAX_RATE_MBS    5
`define STOPT_CLK_MHZ         100
`define STOPT_MIN_PERIOD_NS   (1000 / `STOPT_MAX_RATE_MBS)
`define STOPT_MIN_PERIOD_4NS  8'h32

`endif

// file: hdl/stopt_pkg.sv
package stopt_pkg;

	// Decoded option set taken from the strap header.
	typedef struct packed {
		logic lamp_operating;
		logic sync_request;
		logic parity_check;
		logic retry_unlimited;
		logic ua_report;
		logic legacy_level;
		logic per_default;
	} stopt_opts_type;

	// Sequencer states of the option capture.
	typedef enum logic [1:0] {
		STOPT_IDLE,
		STOPT_SETTLE,
		STOPT_RUN
	} stopt_state_type;

endpackage : stopt_pkg

// file: hdl/stopt_sync.sv
`timescale 1ns/1ps

// Three-stage synchroniser; a change is accepted once stages two and
// three agree, so the first stage feeds nothing but the second.
module stopt_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,      // System clock.
	input  wire logic             reset_n,  // Synchronous reset, low.
	input  wire logic [WIDTH-1:0] d_in,     // Asynchronous input.
	output logic      [WIDTH-1:0] q_out     // Filtered, synchronous value.
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	// Shift chain of three flip-flops.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Output moves only on bits where stages two and three agree.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q_out <= '0;
		end else begin
			q_out <= (q_out & ~(s2_r ~^ s3_r)) | (s2_r & (s2_r ~^ s3_r));
		end
	end

endmodule : stopt_sync

// file: hdl/stopt_apb.sv
`timescale 1ns/1ps
`include "stopt_params.svh"

// APB slave with one wait-free access phase; answers in the first
// access cycle and flags unmapped addresses with pslverr.
module stopt_apb (
	input  wire logic        clk,      // System clock.
	input  wire logic        reset_n,  // Synchronous reset, low.
	input  wire logic        psel,     // APB select.
	input  wire logic        penable,  // APB access phase.
	input  wire logic        pwrite,   // APB direction, high for write.
	input  wire logic [11:0] paddr,    // APB byte address.
	input  wire logic [31:0] pwdata,   // APB write data.
	input  wire logic [31:0] rd_value, // Value of addressed register.
	input  wire logic        rd_hit,   // Address is mapped.
	output logic      [31:0] prdata,   // APB read data.
	output logic             pready,   // APB ready.
	output logic             pslverr,  // APB error.
	output logic             wr_stb,   // One-cycle write strobe.
	output logic      [11:0] wr_addr,  // Write address.
	output logic      [31:0] wr_data   // Write data.
);

	// Ready rises in the cycle after setup, closing the access.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready  <= 1'b1;
			pslverr <= !rd_hit;
			prdata  <= (!pwrite && rd_hit) ? rd_value : 32'h0000_0000;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// The write strobe is registered at the edge that completes the access; registers update one edge later.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_stb  <= 1'b0;
			wr_addr <= 12'h000;
			wr_data <= 32'h0000_0000;
		end else begin
			wr_stb  <= psel && penable && pready && pwrite && !pslverr;
			wr_addr <= paddr;
			wr_data <= pwdata;
		end
	end

endmodule : stopt_apb

// file: hdl/stopt_top.sv
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "stopt_params.svh"

module stopt_top (
	input  wire logic        clk,            // System clock, 100 MHz.
	input  wire logic        reset_n,        // Synchronous reset, low.
	input  wire logic [9:0]  option_strap_header, // Straps, high = closed.
	input  wire logic        psel,           // APB select.
	input  wire logic        penable,        // APB enable.
	input  wire logic        pwrite,         // APB direction.
	input  wire logic [11:0] paddr,          // APB byte address.
	input  wire logic [31:0] pwdata,         // APB write data.
	output logic      [31:0] prdata,         // APB read data.
	output logic             pready,         // APB ready.
	output logic             pslverr,        // APB error.
	input  wire logic        unit_busy,      // Drive is operating.
	input  wire logic        unit_ready,     // Drive is ready.
	input  wire logic        rx_valid,       // Received data byte strobe.
	input  wire logic [7:0]  rx_data,        // Received data byte.
	input  wire logic        rx_parity,      // Received odd parity bit.
	input  wire logic        init_sdtr,      // Initiator sent SDTR pulse.
	input  wire logic [7:0]  init_period,    // Offered period, 4 ns units.
	input  wire logic        resel_fail,     // Reselection attempt failed.
	input  wire logic        resel_done,     // Reselection succeeded.
	output logic             lamp_on,        // Front lamp drive.
	output logic             diag_mode,      // Offline diagnostic mode.
	output logic             sdtr_send,      // Device must originate SDTR.
	output logic             sdtr_reply,     // Reply to initiator SDTR.
	output logic      [7:0]  sdtr_period,    // Agreed period, 4 ns units.
	output logic             sync_enabled,   // Sync data phases allowed.
	output logic             parity_error,   // Parity error flagged.
	output logic             resel_retry,    // Retry reselection again.
	output logic             resel_give_up   // Stop retrying reselection.
);

	// ------------------------------------------------------------------
	// Strap synchronisation and capture.
	// ------------------------------------------------------------------
	logic [9:0]                 straps_s;
	stopt_pkg::stopt_state_type state_r;
	stopt_pkg::stopt_opts_type  opts_r;
	logic [2:0]                 settle_r;

	stopt_sync #(.WIDTH(10)) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d_in    (option_strap_header),
		.q_out   (straps_s)
	);

	// Waits for the synchroniser to settle, then latches the straps once.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_r  <= stopt_pkg::STOPT_IDLE;
			settle_r <= 3'h0;
		end else begin
			unique case (state_r)
				stopt_pkg::STOPT_IDLE: begin
					state_r <= stopt_pkg::STOPT_SETTLE;
				end
				stopt_pkg::STOPT_SETTLE: begin
					settle_r <= settle_r + 3'h1;
					if (settle_r == 3'h7) begin
						state_r <= stopt_pkg::STOPT_RUN;
					end
				end
				stopt_pkg::STOPT_RUN: begin
					state_r <= stopt_pkg::STOPT_RUN;
				end
			endcase
		end
	end

	// Decoded options; strap pairs map to header bits 0 (1-2) up to 8 (17-18).
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			opts_r <= '0;
		end else if (state_r == stopt_pkg::STOPT_SETTLE && settle_r == 3'h7) begin
			opts_r.lamp_operating  <= straps_s[8];
			opts_r.sync_request    <= straps_s[7];
			opts_r.parity_check    <= straps_s[6];
			opts_r.retry_unlimited <= straps_s[4];
			opts_r.ua_report       <= straps_s[3];
			opts_r.legacy_level    <= straps_s[1];
			opts_r.per_default     <= !straps_s[0];
		end
	end

	wire logic running = (state_r == stopt_pkg::STOPT_RUN);

	// ------------------------------------------------------------------
	// Register bus.
	// ------------------------------------------------------------------
	logic        wr_stb;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [31:0] rd_value;
	logic        rd_hit;
	logic [7:0]  cmd_r;
	logic [5:0]  page_r;
	logic [7:0]  alloc_r;
	logic [31:0] result_r;
	logic        saved_valid_r;
	logic        saved_per_r;
	logic        ua_pend_r;
	logic        sdtr_done_r;
	logic [7:0]  retry_cnt_r;

	stopt_apb u_apb (
		.clk      (clk),
		.reset_n  (reset_n),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.rd_value (rd_value),
		.rd_hit   (rd_hit),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.wr_stb   (wr_stb),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data)
	);

	// Returns the word at a register offset and whether it exists.
	function automatic logic [32:0] reg_read(input logic [11:0] a);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		unique case (a)
			`STOPT_OFF_CTRL:   r[31:0] = 32'h0000_0000;
			`STOPT_OFF_STATUS: r[31:0] = {20'h00000, status_word()};
			`STOPT_OFF_CMD:    r[31:0] = {10'h000, page_r, alloc_r, cmd_r};
			`STOPT_OFF_RESULT: r[31:0] = result_r;
			`STOPT_OFF_SAVED:  r[31:0] = {30'h0, saved_per_r, saved_valid_r};
			`STOPT_OFF_RETRY:  r[31:0] = {24'h000000, retry_cnt_r};
			default:           r = 33'h0_0000_0000;
		endcase
		return r;
	endfunction : reg_read

	// Packs the decoded options and live flags into the status word.
	function automatic logic [11:0] status_word();
		logic [11:0] s;
		s = 12'h000;
		s[`STOPT_ST_LAMP_MODE] = opts_r.lamp_operating;
		s[`STOPT_ST_SYNC_REQ]  = opts_r.sync_request;
		s[`STOPT_ST_PARITY_EN] = opts_r.parity_check;
		s[`STOPT_ST_RETRY_INF] = opts_r.retry_unlimited;
		s[`STOPT_ST_UA_RPT]    = opts_r.ua_report;
		s[`STOPT_ST_DIAG]      = diag_mode;
		s[`STOPT_ST_LEGACY]    = opts_r.legacy_level;
		s[`STOPT_ST_PER_DEF]   = effective_per();
		s[`STOPT_ST_UA_PEND]   = ua_pend_r;
		s[`STOPT_ST_PERR]      = parity_error;
		s[`STOPT_ST_SDTR_DUE]  = sdtr_send;
		s[`STOPT_ST_RETRY_OUT] = resel_give_up;
		return s;
	endfunction : status_word

	// Saved mode parameters win over the strap default.
	function automatic logic effective_per();
		return saved_valid_r ? saved_per_r : opts_r.per_default;
	endfunction : effective_per

	always_comb begin
		{rd_hit, rd_value} = reg_read(paddr);
	end

	wire logic wr_ctrl = wr_stb && (wr_addr == `STOPT_OFF_CTRL);

	// Command word and saved mode parameters written by firmware.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cmd_r         <= 8'h00;
			page_r        <= 6'h00;
			alloc_r       <= 8'h00;
			saved_valid_r <= 1'b0;
			saved_per_r   <= 1'b0;
		end else if (wr_stb) begin
			if (wr_addr == `STOPT_OFF_CMD) begin
				cmd_r   <= wr_data[7:0];
				alloc_r <= wr_data[15:8];
				page_r  <= wr_data[21:16];
			end
			if (wr_addr == `STOPT_OFF_SAVED) begin
				saved_valid_r <= wr_data[0];
				saved_per_r   <= wr_data[1];
			end
		end
	end

	// Unit attention pending flag; the set wins over a clear.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ua_pend_r <= 1'b0;
		end else if (wr_ctrl && wr_data[`STOPT_CTRL_UA_SET]) begin
			ua_pend_r <= 1'b1;
		end else if (wr_ctrl && wr_data[`STOPT_CTRL_UA_CLR]) begin
			ua_pend_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Command personality decode.
	// ------------------------------------------------------------------
	// Result: [0] check condition, [1] legacy page length, [2] page
	// omitted, [3] verify uses page 1, [15:8] sense length,
	// [18:16] version, [23:20] format, [31:24] capability byte.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			result_r <= 32'h0000_0000;
		end else begin
			result_r[0] <= opts_r.ua_report && ua_pend_r &&
				cmd_r != `STOPT_OP_INQUIRY &&
				cmd_r != `STOPT_OP_REQ_SENSE &&
				cmd_r != `STOPT_OP_PRIO_RSV;
			result_r[1] <= opts_r.legacy_level &&
				(page_r == `STOPT_PAGE_RW || page_r == `STOPT_PAGE_DISC ||
				page_r == `STOPT_PAGE_GEOM || page_r == `STOPT_PAGE_ALL);
			result_r[2] <= opts_r.legacy_level &&
				page_r == `STOPT_PAGE_ALL;
			result_r[3] <= opts_r.legacy_level &&
				cmd_r == `STOPT_OP_VERIFY;
			result_r[7:4] <= 4'h0;
			result_r[15:8] <= (opts_r.legacy_level && alloc_r == 8'h00) ?
				`STOPT_LEGACY_SENSE : alloc_r;
			result_r[18:16] <= opts_r.legacy_level ?
				`STOPT_VER_OLD : `STOPT_VER_NEW;
			result_r[19] <= !opts_r.legacy_level;
			result_r[23:20] <= opts_r.legacy_level ?
				`STOPT_FMT_OLD : `STOPT_FMT_NEW;
			result_r[31:24] <= opts_r.legacy_level ?
				8'h00 : `STOPT_CAPS_NEW;
		end
	end

	// ------------------------------------------------------------------
	// Lamp and diagnostic mode.
	// ------------------------------------------------------------------
	// The diag strap is followed live; the lamp follows the chosen source.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lamp_on   <= 1'b0;
			diag_mode <= 1'b0;
		end else begin
			diag_mode <= straps_s[2];
			lamp_on   <= running && (opts_r.lamp_operating ?
				unit_busy : unit_ready);
		end
	end

	// ------------------------------------------------------------------
	// Synchronous negotiation.
	// ------------------------------------------------------------------
	// A device-originated request is raised until firmware reports it sent.
	// Asynchronous transfer is never gated by these signals.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sdtr_done_r <= 1'b0;
			sdtr_send   <= 1'b0;
		end else begin
			if (wr_ctrl && wr_data[`STOPT_CTRL_SDTR_SENT]) begin
				sdtr_done_r <= 1'b1;
			end
			sdtr_send <= running && opts_r.sync_request &&
				!sdtr_done_r && !init_sdtr;
		end
	end

	// Replies to any initiator request once running, clamping the period to 5 MB/s.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sdtr_reply   <= 1'b0;
			sdtr_period  <= 8'h00;
			sync_enabled <= 1'b0;
		end else begin
			sdtr_reply <= init_sdtr && running;
			if (init_sdtr && running) begin
				sync_enabled <= 1'b1;
				sdtr_period  <= (init_period < `STOPT_MIN_PERIOD_4NS) ?
					`STOPT_MIN_PERIOD_4NS : init_period;
			end
		end
	end

	// ------------------------------------------------------------------
	// Parity check.
	// ------------------------------------------------------------------
	// Odd parity over the byte; an error sticks until firmware clears it.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			parity_error <= 1'b0;
		end else if (rx_valid && opts_r.parity_check &&
			!(^{rx_data, rx_parity})) begin
			parity_error <= 1'b1;
		end else if (wr_ctrl && wr_data[`STOPT_CTRL_PERR_CLR]) begin
			parity_error <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Reselection retries.
	// ------------------------------------------------------------------
	// Counts failures; beyond ten the device gives up unless unlimited.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			retry_cnt_r   <= 8'h00;
			resel_retry   <= 1'b0;
			resel_give_up <= 1'b0;
		end else if (resel_done) begin
			retry_cnt_r   <= 8'h00;
			resel_retry   <= 1'b0;
			resel_give_up <= 1'b0;
		end else if (resel_fail) begin
			if (opts_r.retry_unlimited ||
				retry_cnt_r < `STOPT_RETRY_LIMIT) begin
				retry_cnt_r <= retry_cnt_r + 8'h01;
				resel_retry <= 1'b1;
			end else begin
				resel_retry   <= 1'b0;
				resel_give_up <= 1'b1;
			end
		end else begin
			resel_retry <= 1'b0;
		end
	end

endmodule : stopt_top

// file: dv/stopt_init.sv
`timescale 1ns/1ps

// Initiator on the far side: sends data bytes, offers a transfer period
// and answers or ignores reselection.
module stopt_init (
	input  wire logic       clk,         // Clock.
	output logic            rx_valid,    // Byte strobe.
	output logic      [7:0] rx_data,     // Data byte.
	output logic            rx_parity,   // Odd parity bit.
	output logic            init_sdtr,   // Offer pulse.
	output logic      [7:0] init_period, // Offered period.
	output logic            resel_fail,  // No answer to reselection.
	output logic            resel_done   // Answered reselection.
);
	// Lines start quiet; released data lines show a changed value.
	initial begin
		{rx_valid, init_sdtr, resel_fail, resel_done} = 4'h0;
		{rx_data, rx_parity, init_period} = 17'h0;
	end

	// Sends one byte; bad gives it the wrong parity.
	task send(input logic [7:0] d, input logic bad);
		@(posedge clk);
		rx_valid  <= 1'b1;
		rx_data   <= d;
		rx_parity <= ~^d ^ bad;
		@(posedge clk);
		rx_valid  <= 1'b0;
		rx_data   <= ~d;
		rx_parity <= ^d;
	endtask : send

	// Offers the period this initiator can receive at.
	task offer(input logic [7:0] post_error_flag);
		@(posedge clk);
		init_sdtr   <= 1'b1;
		init_period <= post_error_flag;
		@(posedge clk);
		init_sdtr   <= 1'b0;
		init_period <= ~post_error_flag;
	endtask : offer

	// Reports a reselection outcome: f high means no answer.
	task resel(input logic f);
		@(posedge clk);
		resel_fail <= f;
		resel_done <= ~f;
		@(posedge clk);
		resel_fail <= 1'b0;
		resel_done <= 1'b0;
	endtask : resel
endmodule : stopt_init

// file: dv/stopt_top_asserts.sv
`timescale 1ns/1ps

// Port-level checks on the strap option decoder.
module stopt_chk (
	input wire logic       clk,                 // Clock.
	input wire logic       reset_n,             // Reset, low.
	input wire logic [9:0] option_strap_header, // Straps.
	input wire logic       unit_busy,           // Operating.
	input wire logic       unit_ready,          // Ready.
	input wire logic       rx_valid,            // Byte strobe.
	input wire logic [7:0] rx_data,             // Byte.
	input wire logic       rx_parity,           // Parity.
	input wire logic       init_sdtr,           // Offer.
	input wire logic [7:0] init_period,         // Offered period.
	input wire logic       resel_fail,          // Failed try.
	input wire logic       lamp_on,             // Lamp.
	input wire logic       diag_mode,           // Diagnostics.
	input wire logic       sdtr_send,           // Originate.
	input wire logic       sdtr_reply,          // Reply.
	input wire logic [7:0] sdtr_period,         // Agreed period.
	input wire logic       sync_enabled,        // Sync allowed.
	input wire logic       parity_error,        // Parity flag.
	input wire logic       resel_retry          // Retry.
);
	logic [3:0] cnt_r;
	logic [9:0] ls_r;
	logic       run;

	// Counts edges since reset so checks wait for the strap capture.
	always_ff @(posedge clk) begin
		if (!reset_n)
			cnt_r <= 4'h0;
		else if (cnt_r != 4'hF)
			cnt_r <= cnt_r + 4'h1;
	end

	// Keeps the straps seen early, as the decoder is meant to.
	always_ff @(posedge clk) begin
		if (cnt_r == 4'h5)
			ls_r <= option_strap_header;
	end
	assign run = (cnt_r == 4'hF);

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	reply_next_a: assert property (init_sdtr |=> sdtr_reply)
		else $error("no reply after an offer");
	rate_clamp_a: assert property (init_sdtr |=> sdtr_period ==
		(($past(init_period) < 8'h32) ? 8'h32 : $past(init_period)))
		else $error("agreed period wrong");
	sync_on_a: assert property (init_sdtr |=> sync_enabled)
		else $error("sync not allowed after offer");
	no_origin_a: assert property (run && !ls_r[7] |-> !sdtr_send)
		else $error("offer originated with strap open");
	parity_off_a: assert property (run && !ls_r[6] |-> !parity_error)
		else $error("parity flagged while unchecked");
	parity_flag_a: assert property (run && ls_r[6] && rx_valid &&
		!(^{rx_data, rx_parity}) |=> parity_error)
		else $error("parity error missed");
	lamp_follow_a: assert property (run |=> lamp_on ==
		(ls_r[8] ? $past(unit_busy) : $past(unit_ready)))
		else $error("lamp wrong");
	diag_on_a: assert property ((run && option_strap_header[2]) [*8]
		|-> diag_mode) else $error("diagnostics not entered");
	diag_off_a: assert property ((run && !option_strap_header[2]) [*8]
		|-> !diag_mode) else $error("diagnostics not left");
	retry_free_a: assert property (run && ls_r[4] && resel_fail
		|=> resel_retry) else $error("unlimited retry stopped");
	retry_cause_a: assert property (resel_retry |-> $past(resel_fail))
		else $error("retry without failure");
endmodule : stopt_chk

bind stopt_top stopt_chk i_chk (
	.clk(clk), .reset_n(reset_n), .option_strap_header(option_strap_header),
	.unit_busy(unit_busy), .unit_ready(unit_ready), .rx_valid(rx_valid),
	.rx_data(rx_data), .rx_parity(rx_parity), .init_sdtr(init_sdtr),
	.init_period(init_period), .resel_fail(resel_fail), .lamp_on(lamp_on),
	.diag_mode(diag_mode), .sdtr_send(sdtr_send), .sdtr_reply(sdtr_reply),
	.sdtr_period(sdtr_period), .sync_enabled(sync_enabled),
	.parity_error(parity_error), .resel_retry(resel_retry)
);

// file: dv/tb_scsi_target_strap_options.sv
`timescale 1ns/1ps
`include "stopt_params.svh"

// Runs strap sets through the decoder and checks its answers.
module tb_scsi_target_strap_options;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, e, ua;
	logic        unit_busy, unit_ready, rx_valid, rx_parity, init_sdtr;
	logic        resel_fail, resel_done, lamp_on, diag_mode, sdtr_send;
	logic        sdtr_reply, sync_enabled, parity_error, resel_retry, give_up;
	logic [7:0]  rx_data, init_period, sdtr_period, p;
	logic [9:0]  strap, s;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [63:0] r;
	int          num_errors, comparisons, seed, k, i;
	localparam logic [7:0] MS = `STOPT_OP_MODE_SENSE;
	localparam logic [7:0] OPS [9] = '{`STOPT_OP_INQUIRY, `STOPT_OP_REQ_SENSE,
		`STOPT_OP_PRIO_RSV, MS, MS, MS, MS, MS, `STOPT_OP_VERIFY};
	localparam logic [5:0] PGS [9] = '{6'h00, 6'h00, 6'h00, 6'h3F, 6'h01,
		6'h02, 6'h04, 6'h07, 6'h08};
	localparam logic [7:0] PT [4] = '{8'h00, 8'h31, 8'h32, 8'hFF};

	stopt_top i_dut (.clk(clk), .reset_n(reset_n), .option_strap_header(strap),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.unit_busy(unit_busy), .unit_ready(unit_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_parity(rx_parity), .init_sdtr(init_sdtr),
		.init_period(init_period), .resel_fail(resel_fail),
		.resel_done(resel_done), .lamp_on(lamp_on), .diag_mode(diag_mode),
		.sdtr_send(sdtr_send), .sdtr_reply(sdtr_reply),
		.sdtr_period(sdtr_period), .sync_enabled(sync_enabled),
		.parity_error(parity_error), .resel_retry(resel_retry),
		.resel_give_up(give_up));
	stopt_init i_init (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_parity(rx_parity), .init_sdtr(init_sdtr),
		.init_period(init_period), .resel_fail(resel_fail),
		.resel_done(resel_done));

	// Clock and random drive activity for the lamp.
	always #5 clk = ~clk;
	always @(posedge clk) {unit_busy, unit_ready} <= 2'($random(seed));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chkb

	// One APB transfer; the answer is taken at the edge that sees pready.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chkb(pready, 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rst(input logic [9:0] st);
		@(posedge clk);
		strap   <= st;
		reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (14) @(posedge clk);
	endtask : rst

	function automatic logic [31:0] exp_st(input logic [9:0] st);
		return {21'h0, st[7], 2'h0, ~st[0], st[1], st[2], st[3], st[4], st[6],
			st[7], st[8]};
	endfunction : exp_st

	// Mask and value of a result; table entries 0 to 2 are exempt commands.
	function automatic logic [63:0] exp_res(input logic [9:0] st, input int j,
		input logic u);
		logic [31:0] m, v;
		m = 32'h1;
		v = {31'h0, u & st[3] & (j > 2)};
		if (OPS[j] == MS) begin
			m[2:1] = 2'h3;
			v[1] = st[1] & (PGS[j] < 6'h07 || PGS[j] == 6'h3F);
			v[2] = st[1] & (PGS[j] == 6'h3F);
		end
		m[3] = (j == 8);
		v[3] = (j == 8) & st[1];
		if (j == 0) begin
			m[31:16] = 16'hFFFF;
			v[31:16] = st[1] ? {8'h00, `STOPT_FMT_OLD, 1'b0, `STOPT_VER_OLD} :
				{`STOPT_CAPS_NEW, `STOPT_FMT_NEW, 1'b1, `STOPT_VER_NEW};
		end
		if (j == 1 && st[1]) begin
			m[15:8] = 8'hFF;
			v[15:8] = `STOPT_LEGACY_SENSE;
		end
		return {m, v};
	endfunction : exp_res

	task wrap_up;
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	// Cuts a hang short.
	initial begin
		#100000;
		num_errors++;
		wrap_up;
	end

	// Main sequence: fixed corner strap sets, then random ones.
	initial begin
		{clk, reset_n, psel, penable, pwrite, paddr, pwdata, strap} = 59'h0;
		{unit_busy, unit_ready, num_errors, comparisons} = 66'h0;
		seed = 32'h810e;
		for (k = 0; k < 6; k++) begin
			s = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : 10'($random(seed));
			rst(s);
			apb(1'b0, `STOPT_OFF_STATUS, 32'h0);
			chk(q, exp_st(s));
			chkb(sdtr_send, s[7]);
			strap <= s ^ 10'h3FB;
			repeat (8) @(posedge clk);
			apb(1'b0, `STOPT_OFF_STATUS, 32'h0);
			chk(q, exp_st(s));
			strap <= s ^ 10'h004;
			repeat (10) @(posedge clk);
			chkb(diag_mode, ~s[2]);
			strap <= s;
			repeat (10) @(posedge clk);
			chkb(sync_enabled, 1'b0);
			for (i = 0; i < 6; i++) begin
				p = (i < 4) ? PT[i] : 8'($random(seed));
				i_init.offer(p);
				#1;
				chkb(sdtr_reply, 1'b1);
				chk({24'h0, sdtr_period}, {24'h0, p < 8'h32 ? 8'h32 : p});
			end
			chkb(sync_enabled, 1'b1);
			apb(1'b1, `STOPT_OFF_CTRL, 32'h4);
			repeat (3) @(posedge clk);
			chkb(sdtr_send, 1'b0);
			for (i = 0; i < 3; i++) begin
				i_init.send(8'($random(seed)), i == 1);
				#1;
				chkb(parity_error, s[6] & (i > 0));
			end
			apb(1'b1, `STOPT_OFF_CTRL, 32'h8);
			repeat (2) @(posedge clk);
			chkb(parity_error, 1'b0);
			for (i = 0; i < 2; i++) begin
				apb(1'b1, `STOPT_OFF_SAVED, {30'h0, i[0], 1'b1});
				apb(1'b0, `STOPT_OFF_STATUS, 32'h0);
				chkb(q[7], i[0]);
			end
			apb(1'b0, 12'h0F0, 32'h0);
			chkb(e, 1'b1);
			chk(q, 32'h0);
			for (i = 1; i <= 11; i++) begin
				i_init.resel(1'b1);
				#1;
				chkb(resel_retry, s[4] | (i <= 10));
			end
			chkb(give_up, ~s[4]);
			i_init.resel(1'b0);
			#1;
			chkb(give_up, 1'b0);
			ua = 1'($random(seed));
			if (ua)
				apb(1'b1, `STOPT_OFF_CTRL, 32'h1);
			for (i = 0; i < 9; i++) begin
				p = (i == 1) ? 8'h00 : 8'($random(seed));
				apb(1'b1, `STOPT_OFF_CMD, {10'h0, PGS[i], p, OPS[i]});
				@(posedge clk);
				apb(1'b0, `STOPT_OFF_RESULT, 32'h0);
				r = exp_res(s, i, ua);
				chk(q & r[63:32], r[31:0]);
			end
			$display("strap set %h done", s);
		end
		wrap_up;
	end
endmodule : tb_scsi_target_strap_options
